/* rtcac_map.svh */
// Register offsets, field positions and reset values of the clock block.
// Assumes byte addresses on a 16-bit offset bus, 32-bit word data.
`ifndef RTCAC_MAP_SVH
`define RTCAC_MAP_SVH

`define RTCAC_OFS_ALARM_CONTROL    16'h0010
`define RTCAC_OFS_TIME_VALUE       16'h0020
`define RTCAC_OFS_DATE_VALUE       16'h0030
`define RTCAC_OFS_ALARM_TIME_VALUE 16'h0040
`define RTCAC_OFS_ALARM_DATE_VALUE 16'h0050
`define RTCAC_OFS_CLOCK_CONTROL    16'h0C00

`define RTCAC_ALIAS_PLAIN 2'h0
`define RTCAC_ALIAS_CLR   2'h1
`define RTCAC_ALIAS_SET   2'h2
`define RTCAC_ALIAS_INV   2'h3

`define RTCAC_RST_ALARM_CONTROL 32'h0000_0000
`define RTCAC_RST_CLOCK_CONTROL 32'h0000_0000

// Clock control bits
`define RTCAC_CC_ON         15
`define RTCAC_CC_WRITE_UNLK 3
`define RTCAC_CC_SYNC       2
`define RTCAC_CC_HALFSEC    1
`define RTCAC_CC_MASK       32'h03FF_AFFF

// Alarm control bits
`define RTCAC_AC_ENABLE     15
`define RTCAC_AC_CONT_RPT   14
`define RTCAC_AC_PULSE      13
`define RTCAC_AC_SYNC       12
`define RTCAC_AC_MASK       32'h0000_FFFF

// Valid bits of the value registers
`define RTCAC_TIME_MASK     32'hFFFF_FF00
`define RTCAC_DATE_MASK     32'hFFFF_FF0F
`define RTCAC_ADATE_MASK    32'h00FF_FF0F

// Ticks per second at 100 MHz
`define RTCAC_CLK_HZ        100000000
`define RTCAC_SEC_TICKS     (`RTCAC_CLK_HZ)

`endif

/* rtcac_pkg.sv */
// Types shared by the clock block.
// Assumes the map header is compiled alongside.
`default_nettype none
package rtcac_pkg;
  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rtcac_bus_req_t;

  typedef enum logic [1:0] {
    RTCAC_AL_IDLE,
    RTCAC_AL_FIRED
  } rtcac_al_state_t;
endpackage
`default_nettype wire

/* rtcac_top.sv */
// Real-time clock and calendar with alarm and repeat counter.
// Assumes a single 100 MHz clock and a power-on reset separate from RSTN_I.
//
// Local design decision: strobed register access.
`include "rtcac_map.svh"
`default_nettype none

module rtcac_top
  import rtcac_pkg::*;
#(
  parameter int unsigned SEC_TICKS = `RTCAC_SEC_TICKS
) (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  input  wire logic        POR_N_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output var  logic [31:0] RDATA_O,
  output var  logic        ALARM_EVT_O,
  output var  logic        SEC_TICK_O
);

  rtcac_bus_req_t req;
  assign req = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

  logic [31:0] ctl_q, alc_q, time_q, date_q, atime_q, adate_q;
  logic [31:0] time_d, date_d, alc_d;
  logic [31:0] cnt_q;
  logic        tick;
  logic        fire;
  logic [1:0]  alias_sel;
  logic [15:0] base;
  logic        hit_ctl, hit_alc, hit_tim, hit_dat, hit_atm, hit_adt;
  logic        match_q;
  rtcac_al_state_t al_state_q;

  assign alias_sel = req.addr[3:2];
  assign base      = {req.addr[15:4], 4'h0};
  assign hit_ctl   = base == `RTCAC_OFS_CLOCK_CONTROL;
  assign hit_alc   = base == `RTCAC_OFS_ALARM_CONTROL;
  assign hit_tim   = base == `RTCAC_OFS_TIME_VALUE;
  assign hit_dat   = base == `RTCAC_OFS_DATE_VALUE;
  assign hit_atm   = base == `RTCAC_OFS_ALARM_TIME_VALUE;
  assign hit_adt   = base == `RTCAC_OFS_ALARM_DATE_VALUE;

  // Plain, clear, set, invert write of one register
  function automatic logic [31:0] alias_wr(input logic [31:0] cur,
                                           input logic [31:0] wd,
                                           input logic [1:0]  sel,
                                           input logic [31:0] msk);
    logic [31:0] r;
    r = cur;
    case (sel)
      `RTCAC_ALIAS_PLAIN: r = wd;
      `RTCAC_ALIAS_CLR:   r = cur & ~wd;
      `RTCAC_ALIAS_SET:   r = cur | wd;
      default:            r = cur ^ wd;
    endcase
    return r & msk;
  endfunction

  // BCD digit increment with wrap limit; carry out on wrap
  function automatic logic [4:0] bcd_inc(input logic [3:0] d,
                                         input logic [3:0] hi,
                                         input logic [3:0] lo);
    logic [4:0] r;
    r = (d >= hi) ? {1'b1, lo} : {1'b0, d + 4'h1};
    return r;
  endfunction

  // Second divider
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      cnt_q <= 32'h0000_0000;
    end else if (!ctl_q[`RTCAC_CC_ON] || cnt_q >= SEC_TICKS - 1) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end
  assign tick = ctl_q[`RTCAC_CC_ON] && (cnt_q == SEC_TICKS - 1);

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SEC_TICK_O <= 1'b0;
    end else begin
      SEC_TICK_O <= tick;
    end
  end

  // Calendar advance with BCD carries
  always_comb begin
    logic [4:0] s1, s10, m1, m10, h1, h10, d1, d10, mo1, mo10, y1, y10;
    logic       c;
    logic [3:0] maxday;
    s1 = 5'h00; s10 = 5'h00; m1 = 5'h00; m10 = 5'h00; h1 = 5'h00;
    h10 = 5'h00; d1 = 5'h00; d10 = 5'h00; mo1 = 5'h00; mo10 = 5'h00;
    y1 = 5'h00; y10 = 5'h00; c = 1'b0; maxday = 4'h0;
    time_d = time_q;
    date_d = date_q;
    if (tick) begin
      s1 = bcd_inc(time_q[11:8], 4'h9, 4'h0);
      time_d[11:8] = s1[3:0];
      if (s1[4]) begin
        s10 = bcd_inc(time_q[15:12], 4'h5, 4'h0);
        time_d[15:12] = s10[3:0];
        if (s10[4]) begin
          m1 = bcd_inc(time_q[19:16], 4'h9, 4'h0);
          time_d[19:16] = m1[3:0];
          if (m1[4]) begin
            m10 = bcd_inc(time_q[23:20], 4'h5, 4'h0);
            time_d[23:20] = m10[3:0];
            if (m10[4]) begin
              if (time_q[31:28] == 4'h2 && time_q[27:24] >= 4'h3) begin
                time_d[31:24] = 8'h00;
                c = 1'b1;
              end else begin
                h1 = bcd_inc(time_q[27:24], 4'h9, 4'h0);
                time_d[27:24] = h1[3:0];
                if (h1[4]) begin
                  time_d[31:28] = time_q[31:28] + 4'h1;
                end
              end
            end
          end
        end
      end
      if (c) begin
        date_d[3:0] = (date_q[3:0] >= 4'h6) ? 4'h0
                                             : date_q[3:0] + 4'h1;
        case (date_q[23:16])
          8'h02:          maxday = 4'h8;
          8'h04, 8'h06,
          8'h09, 8'h11:   maxday = 4'h0;
          default:        maxday = 4'h1;
        endcase
        if (date_q[23:16] == 8'h02 &&
            date_q[25:24] == {date_q[28], 1'b0}) begin
          maxday = 4'h9; // Leap year: year digits divisible by four
        end
        if ((date_q[23:16] == 8'h02 && date_q[15:8] == {4'h2, maxday}) ||
            (date_q[23:16] != 8'h02 && date_q[15:8] == {4'h3, maxday})) begin
          date_d[15:8] = 8'h01;
          if (date_q[23:16] == 8'h12) begin
            date_d[23:16] = 8'h01;
            y1 = bcd_inc(date_q[27:24], 4'h9, 4'h0);
            date_d[27:24] = y1[3:0];
            if (y1[4]) begin
              y10 = bcd_inc(date_q[31:28], 4'h9, 4'h0);
              date_d[31:28] = y10[3:0];
            end
          end else begin
            mo1 = bcd_inc(date_q[19:16], 4'h9, 4'h0);
            date_d[19:16] = mo1[3:0];
            if (mo1[4]) begin
              date_d[23:20] = 4'h1;
            end
          end
        end else begin
          d1 = bcd_inc(date_q[11:8], 4'h9, 4'h0);
          date_d[11:8] = d1[3:0];
          if (d1[4]) begin
            date_d[15:12] = date_q[15:12] + 4'h1;
          end
        end
      end
    end
    d10 = 5'h00;
    mo10 = 5'h00;
  end

  // Clock control
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctl_q <= `RTCAC_RST_CLOCK_CONTROL;
    end else if (req.wr && hit_ctl) begin
      ctl_q <= alias_wr(ctl_q, req.wdata, alias_sel, `RTCAC_CC_MASK);
    end
  end

  // Time and date; a write beats the same-cycle advance
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      time_q <= 32'h0000_0000;
      date_q <= 32'h0001_0100;
    end else begin
      if (req.wr && hit_tim && ctl_q[`RTCAC_CC_WRITE_UNLK]) begin
        time_q <= alias_wr(time_q, req.wdata, alias_sel,
                           `RTCAC_TIME_MASK);
      end else begin
        time_q <= time_d;
      end
      if (req.wr && hit_dat && ctl_q[`RTCAC_CC_WRITE_UNLK]) begin
        date_q <= alias_wr(date_q, req.wdata, alias_sel, `RTCAC_DATE_MASK);
      end else begin
        date_q <= date_d;
      end
    end
  end

  // Alarm time and date
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      atime_q <= 32'h0000_0000;
      adate_q <= 32'h0000_0000;
    end else begin
      if (req.wr && hit_atm) begin
        atime_q <= alias_wr(atime_q, req.wdata, alias_sel, `RTCAC_TIME_MASK);
      end
      if (req.wr && hit_adt) begin
        adate_q <= alias_wr(adate_q, req.wdata, alias_sel,
                            `RTCAC_ADATE_MASK);
      end
    end
  end

  // Masked compare of current and alarm time
  logic match;
  always_comb begin
    match = 1'b0;
    case (alc_q[11:8])
      4'h0: match = 1'b1;
      4'h1: match = time_q[11:8] == atime_q[11:8];
      4'h2: match = time_q[15:8] == atime_q[15:8];
      4'h3: match = time_q[19:8] == atime_q[19:8];
      4'h4: match = time_q[23:8] == atime_q[23:8];
      4'h5: match = time_q[31:8] == atime_q[31:8];
      4'h6: match = time_q[31:8] == atime_q[31:8] &&
                    date_q[3:0] == adate_q[3:0];
      4'h7: match = time_q[31:8] == atime_q[31:8] &&
                    date_q[15:8] == adate_q[15:8];
      4'h8: match = time_q[31:8] == atime_q[31:8] &&
                    date_q[23:8] == adate_q[23:8];
      default: match = 1'b0;
    endcase
  end

  // One event per matching second
  assign fire = alc_q[`RTCAC_AC_ENABLE] && SEC_TICK_O && match;

  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      al_state_q  <= RTCAC_AL_IDLE;
      ALARM_EVT_O <= 1'b0;
      match_q     <= 1'b0;
    end else begin
      ALARM_EVT_O <= fire;
      match_q     <= match;
      case (al_state_q)
        RTCAC_AL_IDLE:  al_state_q <= fire ? RTCAC_AL_FIRED : RTCAC_AL_IDLE;
        RTCAC_AL_FIRED: al_state_q <= RTCAC_AL_IDLE;
        default:        al_state_q <= RTCAC_AL_IDLE;
      endcase
    end
  end

  // Alarm control next value; hardware event wins over software write
  always_comb begin
    alc_d = alc_q;
    if (req.wr && hit_alc) begin
      alc_d = alias_wr(alc_q, req.wdata, alias_sel, `RTCAC_AC_MASK);
    end
    alc_d[`RTCAC_AC_SYNC] = ctl_q[`RTCAC_CC_ON] &&
                            cnt_q >= SEC_TICKS - 3;
    if (fire) begin
      alc_d[`RTCAC_AC_PULSE] = ~alc_q[`RTCAC_AC_PULSE];
      if (alc_q[7:0] != 8'h00 || alc_q[`RTCAC_AC_CONT_RPT]) begin
        alc_d[7:0] = alc_q[7:0] - 8'h01;
      end else begin
        alc_d[`RTCAC_AC_ENABLE] = 1'b0;
      end
    end
  end

  // Held only by power-on reset
  always_ff @(posedge CLK_SYS_I or negedge POR_N_I) begin
    if (!POR_N_I) begin
      alc_q <= `RTCAC_RST_ALARM_CONTROL;
    end else begin
      alc_q <= alc_d;
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RDATA_O <= 32'h0000_0000;
    end else if (req.rd && alias_sel == `RTCAC_ALIAS_PLAIN) begin
      RDATA_O <= hit_ctl ? ctl_q :
                 hit_alc ? alc_q :
                 hit_tim ? time_q :
                 hit_dat ? date_q :
                 hit_atm ? atime_q :
                 hit_adt ? adate_q : 32'h0000_0000;
    end else begin
      RDATA_O <= 32'h0000_0000;
    end
  end

  a_repeat_dec: assert property (@(posedge CLK_SYS_I) disable iff (!POR_N_I)
    fire && alc_q[7:0] != 8'h00 |=> alc_q[7:0] == $past(alc_q[7:0]) - 8'h01)
    else $error("repeat count not decremented");
  a_repeat_wrap: assert property (@(posedge CLK_SYS_I) disable iff (!POR_N_I)
    fire && alc_q[7:0] == 8'h00 && alc_q[14] |=> alc_q[7:0] == 8'hFF)
    else $error("repeat count did not wrap");
  a_enable_clear: assert property (@(posedge CLK_SYS_I) disable iff (!POR_N_I)
    fire && alc_q[7:0] == 8'h00 && !alc_q[14]
    |=> !alc_q[15] && alc_q[7:0] == 8'h00)
    else $error("alarm enable not cleared at end");
  a_time_locked: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    req.wr && hit_tim && !ctl_q[3] && !tick |=> $stable(time_q))
    else $error("locked time written");
  a_time_low: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    time_q[7:0] == 8'h00)
    else $error("time low byte not zero");
  a_sec_digit: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    tick && time_q[11:8] == 4'h9 && !(req.wr && hit_tim)
    |=> time_q[11:8] == 4'h0)
    else $error("second units did not carry");
  a_weekday_rng: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    tick && date_q[3:0] == 4'h6 && time_q[31:8] == 24'h235959
    && !(req.wr && hit_dat) |=> date_q[3:0] == 4'h0)
    else $error("weekday out of range");
  a_fire_cause: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    ALARM_EVT_O |-> $past(alc_q[15]) && match_q &&
    al_state_q == RTCAC_AL_FIRED)
    else $error("alarm without enable and match");
  a_set_alias: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    req.wr && hit_atm && alias_sel == 2'h2
    |=> (atime_q & $past(req.wdata) & 32'hFFFF_FF00)
        == ($past(req.wdata) & 32'hFFFF_FF00))
    else $error("set alias failed");

endmodule // rtcac_top
`default_nettype wire

/* rtcac_tb.sv */
// Self-checking bench for the clock, calendar and alarm repeat logic.
// Assumes the map header, package and top module are compiled first.
`include "rtcac_map.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          ST    = 20;
  localparam int          LIMIT = 3000;
  localparam logic [31:0] FM    = 32'hFFFF_FFFF;
  localparam logic [15:0] AC    = `RTCAC_OFS_ALARM_CONTROL;
  localparam logic [15:0] TV    = `RTCAC_OFS_TIME_VALUE;
  localparam logic [15:0] DV    = `RTCAC_OFS_DATE_VALUE;
  localparam logic [15:0] CC    = `RTCAC_OFS_CLOCK_CONTROL;
  localparam logic [15:0] AT    = `RTCAC_OFS_ALARM_TIME_VALUE;
  localparam logic [15:0] AD    = `RTCAC_OFS_ALARM_DATE_VALUE;
  logic        clk_sys_i = 1'b0;
  logic        rstn_i    = 1'b0;
  logic        por_n_i   = 1'b0;
  logic        wr_i      = 1'b0;
  logic        rd_i      = 1'b0;
  logic        rd_seen   = 1'b0;
  logic [15:0] addr_i    = 16'h0000;
  logic [31:0] wdata_i   = 32'h0000_0000;
  logic [31:0] rdata_o;
  logic        alarm_evt_o;
  logic        sec_tick_o;
  logic [31:0] q_exp[$];
  logic [31:0] q_msk[$];
  string       q_nm[$];
  int          errors  = 0;
  int          n_tests = 0;
  int          n_evt   = 0;
  int          cyc     = 0;
  int          e0;
  logic [31:0] t;

  rtcac_top #(.SEC_TICKS(ST)) dut (
    .CLK_SYS_I  (clk_sys_i),
    .RSTN_I     (rstn_i),
    .POR_N_I    (por_n_i),
    .ADDR_I     (addr_i),
    .WDATA_I    (wdata_i),
    .WR_I       (wr_i),
    .RD_I       (rd_i),
    .RDATA_O    (rdata_o),
    .ALARM_EVT_O(alarm_evt_o),
    .SEC_TICK_O (sec_tick_o)
  );

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i    <= 1'b0;
  endtask

  // Notes the expectation, the monitor compares the answer
  task automatic rd(input logic [15:0] a, input logic [31:0] m,
                    input logic [31:0] e, input string nm);
    @(posedge clk_sys_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    q_exp.push_back(e & m);
    q_msk.push_back(m);
    q_nm.push_back(nm);
    @(posedge clk_sys_i);
    rd_i   <= 1'b0;
  endtask

  task automatic ck(input string nm, input int e, input int s);
    n_tests++;
    if (e != s) begin
      errors++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, s);
    end
  endtask

  task automatic wait_hi(input bit alarm);
    int i;
    for (i = 0; i < 4 * ST; i++) begin
      @(posedge clk_sys_i);
      if ((alarm ? alarm_evt_o : sec_tick_o) === 1'b1) break;
    end
  endtask

  task automatic pulse_rst(input bit por);
    @(posedge clk_sys_i);
    rstn_i  <= 1'b0;
    por_n_i <= ~por;
    repeat (2) @(posedge clk_sys_i);
    rstn_i  <= 1'b1;
    por_n_i <= 1'b1;
  endtask

  // Read answer stands one cycle after the strobe
  always @(posedge clk_sys_i) begin
    if (rd_seen && q_exp.size() > 0) begin
      n_tests++;
      if ((rdata_o & q_msk[0]) !== q_exp[0]) begin
        errors++;
        $display("[FAIL] %s expected %h seen %h", q_nm[0], q_exp[0],
                 rdata_o & q_msk[0]);
      end
      void'(q_exp.pop_front());
      void'(q_msk.pop_front());
      void'(q_nm.pop_front());
    end
    rd_seen <= rd_i;
    if (alarm_evt_o === 1'b1) n_evt++;
    cyc++;
    if (cyc > LIMIT) begin
      errors++;
      $display("[FAIL] timeout expected done seen running");
      stop_test();
    end
  end

  initial begin
    void'($urandom(32'h92E0B57C));
    repeat (3) @(posedge clk_sys_i);
    rstn_i  <= 1'b1;
    por_n_i <= 1'b1;
    rd(AC, FM, `RTCAC_RST_ALARM_CONTROL, "alarm_control");
    rd(CC, FM, `RTCAC_RST_CLOCK_CONTROL, "clock_control");
    rd(TV, FM, 32'h0000_0000, "time_value");
    rd(DV, FM, 32'h0001_0100, "date_value");
    $display("test reset values done");

    wr(TV, 32'h1234_5600);
    rd(TV, FM, 32'h0000_0000, "time_value locked");
    wr(CC + 16'h8, 32'h0000_0008);
    for (int k = 0; k < 4; k++) begin
      t = {4'($urandom % 3), 4'($urandom % 10), 4'($urandom % 6),
           4'($urandom % 10), 4'($urandom % 6), 4'($urandom % 10),
           8'hFF};
      wr(TV, t);
      rd(TV, FM, t & 32'hFFFF_FF00, "time_value digits");
    end
    $display("test time write lock done");

    wr(AC, 32'h0000_00F0);
    wr(AC + 16'h8, 32'h0000_000F);
    rd(AC, FM, 32'h0000_00FF, "alarm_control set");
    wr(AC + 16'h4, 32'h0000_00F0);
    rd(AC, FM, 32'h0000_000F, "alarm_control clear");
    wr(AC + 16'hC, 32'h0000_00FF);
    rd(AC, FM, 32'h0000_00F0, "alarm_control invert");
    rd(AC + 16'h4, FM, 32'h0000_0000, "alias read");
    wr(AT + 16'h8, 32'h1234_56FF);
    rd(AT, FM, 32'h1234_5600, "alarm_time set");
    wr(AD, FM);
    rd(AD, FM, 32'h00FF_FF0F, "alarm_date bits");
    wr(16'h0100, FM);
    rd(16'h0100, FM, 32'h0000_0000, "unmapped read");
    $display("test alias access done");

    wr(AC, 32'h0000_0A05);
    pulse_rst(1'b0);
    rd(AC, FM, 32'h0000_0A05, "alarm_control kept");
    rd(CC, FM, 32'h0000_0000, "clock_control reset");
    pulse_rst(1'b1);
    rd(AC, FM, 32'h0000_0000, "alarm_control por");
    $display("test reset sources done");

    wr(CC + 16'h8, 32'h0000_0008);
    wr(TV, 32'h2359_5900);
    wr(DV, 32'h0012_3106);
    wr(CC + 16'h8, 32'h0000_8000);
    wait_hi(1'b0);
    repeat (2) @(posedge clk_sys_i);
    wr(CC + 16'h4, 32'h0000_8000);
    rd(TV, FM, 32'h0000_0000, "time_value carry");
    rd(DV, FM, 32'h0101_0100, "date_value carry");
    $display("test calendar carry done");

    // Alarm setup only while the clock is off
    wr(AC, 32'h0000_8002);
    e0 = n_evt;
    wr(CC + 16'h8, 32'h0000_8000);
    repeat (6 * ST) @(posedge clk_sys_i);
    wr(CC + 16'h4, 32'h0000_8000);
    ck("alarm events", 3, n_evt - e0);
    rd(AC, 32'hFFFF_EFFF, 32'h0000_2000, "alarm stop");
    $display("test alarm repeat done");

    wr(AC, 32'h0000_C000);
    e0 = n_evt;
    wr(CC + 16'h8, 32'h0000_8000);
    wait_hi(1'b1);
    wr(CC + 16'h4, 32'h0000_8000);
    ck("continuous_repeat events", 1, n_evt - e0);
    rd(AC, 32'hFFFF_EFFF, 32'h0000_E0FF, "alarm wrap");
    $display("test continuous repeat done");

    wr(TV, 32'h0000_0000);
    wr(AT, 32'h0000_0300);
    wr(AC, 32'h0000_8104);
    e0 = n_evt;
    wr(CC + 16'h8, 32'h0000_8000);
    repeat (5 * ST) @(posedge clk_sys_i);
    wr(CC + 16'h4, 32'h0000_8000);
    ck("masked events", 1, n_evt - e0);
    rd(AC, 32'hFFFF_EFFF, 32'h0000_A103, "alarm mask");
    repeat (3) @(posedge clk_sys_i);
    $display("test alarm mask done");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
